// ==== design/pfl_pkg.sv ====
package pfl_pkg;
	// Command codes on the link
	localparam logic [7:0] CMD_CUR_WARN     = 8'h4a;
	localparam logic [7:0] CMD_OT_FAULT     = 8'h4f;
	localparam logic [7:0] CMD_OT_ACTION    = 8'h50;
	localparam logic [7:0] CMD_OT_WARN      = 8'h51;
	localparam logic [7:0] CMD_VIN_OV       = 8'h55;
	localparam logic [7:0] CMD_VIN_OV_ACT   = 8'h56;
	localparam logic [7:0] CMD_PG_ON        = 8'h5e;
	localparam logic [7:0] CMD_PG_OFF       = 8'h5f;
	localparam logic [7:0] CMD_TON          = 8'h60;
	localparam logic [7:0] CMD_STATUS       = 8'h79;

	// Limits: amps, degrees C, volts, decivolts (power good), milliseconds
	localparam logic [15:0] CUR_WARN_MIN    = 16'h0014;
	localparam logic [15:0] CUR_WARN_MAX    = 16'h004a;
	localparam logic [15:0] OC_FAULT_LIMIT  = 16'h0050;
	localparam logic [15:0] OT_FAULT_MIN    = 16'h0019;
	localparam logic [15:0] OT_FAULT_MAX    = 16'h008c;
	localparam logic [15:0] OT_WARN_MIN     = 16'h0019;
	localparam logic [15:0] OT_WARN_MAX     = 16'h007d;
	localparam logic [15:0] VIN_OV_MIN      = 16'h0030;
	localparam logic [15:0] VIN_OV_MAX      = 16'h005a;
	localparam logic [15:0] PG_ON_MIN       = 16'h005c;
	localparam logic [15:0] PG_ON_MAX       = 16'h0075;
	localparam logic [15:0] PG_OFF_MIN      = 16'h004c;
	localparam logic [15:0] PG_OFF_MAX      = 16'h0065;
	localparam logic [15:0] PG_GAP          = 16'h0010;
	localparam logic [15:0] TON_MAX         = 16'h01f4;

	// Reset values
	localparam logic [15:0] CUR_WARN_RST    = 16'h003c;
	localparam logic [15:0] OT_FAULT_RST    = 16'h007d;
	localparam logic [15:0] OT_WARN_RST     = 16'h006e;
	localparam logic [15:0] VIN_OV_RST      = 16'h0041;
	localparam logic [15:0] PG_ON_RST       = 16'h006c;
	localparam logic [15:0] PG_OFF_RST      = 16'h005a;
	localparam logic [15:0] TON_RST         = 16'h000a;

	// Fault action byte layout
	localparam int          ACT_RETRY_LSB   = 3;
	localparam logic [1:0]  OT_RESPONSE     = 2'h2;
	localparam logic [1:0]  VIN_OV_RESPONSE = 2'h3;
	localparam logic [2:0]  RETRY_NONE      = 3'h0;
	localparam logic [2:0]  RETRY_CONT      = 3'h7;
	localparam logic [2:0]  ACT_DELAY       = 3'h0;
	localparam logic [2:0]  OC_RETRY        = RETRY_CONT;
	localparam logic [2:0]  OT_RETRY_RST    = RETRY_CONT;

	// Status word bit positions
	localparam int ST_VOUT    = 15;
	localparam int ST_IOUT    = 14;
	localparam int ST_INPUT   = 13;
	localparam int ST_PG_N    = 11;
	localparam int ST_OFF     = 6;
	localparam int ST_VOUT_OV = 5;
	localparam int ST_IOUT_OC = 4;
	localparam int ST_VIN_UV  = 3;
	localparam int ST_TEMP    = 2;
	localparam int ST_CML     = 1;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int TON_UNIT_NS   = 1000000;
	localparam int MS_CYCLES     = (TON_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Controller registers (AXI4-Lite byte offsets)
	localparam logic [3:0] HREG_CMD    = 4'h0;
	localparam logic [3:0] HREG_WDATA  = 4'h4;
	localparam logic [3:0] HREG_STATUS = 4'h8;
	localparam logic [3:0] HREG_RDATA  = 4'hc;
	localparam int         HCMD_WRITE_BIT = 8;
	localparam int         HST_BUSY_BIT   = 0;
	localparam int         HST_ERR_BIT    = 1;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PFL_OFF     = 2'b00,
		PFL_DELAY   = 2'b01,
		PFL_ON      = 2'b10,
		PFL_LATCHED = 2'b11
	} pfl_pwr_e;
endpackage

// ==== design/pfl_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pfl_if;
	logic        req;
	logic        write;
	logic [7:0]  code;
	logic [15:0] wdata;
	logic        ack;
	logic        err;
	logic [15:0] rdata;

	modport host (output req, write, code, wdata, input ack, err, rdata);
	modport dev  (input req, write, code, wdata, output ack, err, rdata);
endinterface
`default_nettype wire

// ==== design/pfl_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfl_dev
	import pfl_pkg::*;
#(
	parameter int MS_CYCLES_P = pfl_pkg::MS_CYCLES
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	pfl_if.dev               link,
	input  wire logic        on_cmd_i,
	input  wire logic        bias_ok_i,
	input  wire logic [15:0] iout_i,
	input  wire logic [15:0] temp_i,
	input  wire logic [15:0] vin_i,
	input  wire logic [15:0] vout_i,
	input  wire logic        vout_ov_i,
	input  wire logic        vin_uv_i,
	output logic             out_en_o,
	output logic             pgood_o,
	output logic [15:0]      status_o
);
	import pfl_pkg::*;
	if (MS_CYCLES_P < 1) begin : g_chk
		$error("MS_CYCLES_P must be at least 1");
	end
	typedef struct packed {
		pfl_pwr_e    state;
		logic [31:0] tick;
		logic [15:0] ms;
		logic [15:0] cur_warn;
		logic [15:0] ot_fault;
		logic [15:0] ot_warn;
		logic [15:0] vin_ov;
		logic [15:0] pg_on;
		logic [15:0] pg_off;
		logic [15:0] ton;
		logic [2:0]  ot_retry;
		logic        cml;
		logic        pgood;
		logic        out_en;
		logic        ack;
		logic        err;
		logic [15:0] rdata;
		logic [15:0] status;
	} pfl_dev_s;
	pfl_dev_s s;
	pfl_dev_s next_s;
	logic       oc_fault;
	logic       oc_warn;
	logic       ot_flt;
	logic       ot_wrn;
	logic       vin_ovf;
	logic       run_ok;
	logic       cml_set;
	logic       cml_clr;
	logic [2:0] wr_retry;
	logic [7:0] ot_action;
	// Measurements come from the monitor logic on this same clock
	assign oc_fault  = iout_i > OC_FAULT_LIMIT;
	assign oc_warn   = iout_i > s.cur_warn;
	assign ot_flt    = temp_i > s.ot_fault;
	assign ot_wrn    = temp_i > s.ot_warn;
	assign vin_ovf   = vin_i > s.vin_ov;
	assign run_ok    = on_cmd_i && bias_ok_i;
	assign wr_retry  = link.wdata[ACT_RETRY_LSB +: 3];
	assign ot_action = {OT_RESPONSE, s.ot_retry, ACT_DELAY};
	always_comb begin
		next_s  = s;
		cml_set = 1'b0;
		cml_clr = 1'b0;
		case (s.state)
			PFL_OFF: begin
				if (run_ok && !vin_ovf) begin
					next_s.state = PFL_DELAY;
					next_s.tick  = 32'h0;
					next_s.ms    = 16'h0;
				end
			end
			PFL_DELAY: begin
				if (!run_ok || vin_ovf) begin
					next_s.state = PFL_OFF;
				end else if (s.ms >= s.ton) begin
					next_s.state = PFL_ON;
				end else if (s.tick == 32'(MS_CYCLES_P - 1)) begin
					next_s.tick = 32'h0;
					next_s.ms   = s.ms + 16'h1;
				end else begin
					next_s.tick = s.tick + 32'h1;
				end
			end
			PFL_ON: begin
				// Shutdown is taken on the very next edge: no delay cycles
				if (!run_ok || vin_ovf) begin
					next_s.state = PFL_OFF;
				end else if (ot_flt) begin
					next_s.state = (s.ot_retry == RETRY_CONT) ? PFL_DELAY : PFL_LATCHED;
				end else if (oc_fault) begin
					next_s.state = (OC_RETRY == RETRY_CONT) ? PFL_DELAY : PFL_LATCHED;
				end
				if (next_s.state == PFL_DELAY) begin
					next_s.tick = 32'h0;
					next_s.ms   = 16'h0;
				end
			end
			PFL_LATCHED: begin
				// Only a power-off command or loss of bias releases a latch
				if (!run_ok) begin
					next_s.state = PFL_OFF;
				end
			end
			default: next_s.state = PFL_OFF;
		endcase
		next_s.out_en = next_s.state == PFL_ON;
		if (!s.out_en) begin
			next_s.pgood = 1'b0;
		end else if (vout_i >= s.pg_on) begin
			next_s.pgood = 1'b1;
		end else if (vout_i <= s.pg_off) begin
			next_s.pgood = 1'b0;
		end
		next_s.ack = 1'b0;
		if (link.req && !s.ack) begin
			next_s.ack   = 1'b1;
			next_s.err   = 1'b0;
			next_s.rdata = 16'h0;
			if (link.write) begin
				case (link.code)
					CMD_CUR_WARN: begin
						if (link.wdata >= CUR_WARN_MIN && link.wdata <= CUR_WARN_MAX
							&& link.wdata < OC_FAULT_LIMIT) begin
							next_s.cur_warn = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_OT_FAULT: begin
						if (link.wdata >= OT_FAULT_MIN && link.wdata <= OT_FAULT_MAX
							&& link.wdata > s.ot_warn) begin
							next_s.ot_fault = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_OT_WARN: begin
						if (link.wdata >= OT_WARN_MIN && link.wdata <= OT_WARN_MAX
							&& link.wdata < s.ot_fault) begin
							next_s.ot_warn = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_OT_ACTION: begin
						// Response and delay fields are fixed; only retry is taken
						if (wr_retry == RETRY_NONE || wr_retry == RETRY_CONT) begin
							next_s.ot_retry = wr_retry;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_VIN_OV: begin
						if (link.wdata >= VIN_OV_MIN && link.wdata <= VIN_OV_MAX) begin
							next_s.vin_ov = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_VIN_OV_ACT: ;
					CMD_PG_ON: begin
						if (link.wdata >= PG_ON_MIN && link.wdata <= PG_ON_MAX
							&& link.wdata >= s.pg_off + PG_GAP) begin
							next_s.pg_on = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_PG_OFF: begin
						if (link.wdata >= PG_OFF_MIN && link.wdata <= PG_OFF_MAX
							&& link.wdata + PG_GAP <= s.pg_on) begin
							next_s.pg_off = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_TON: begin
						if (link.wdata <= TON_MAX) begin
							next_s.ton = link.wdata;
						end else begin
							next_s.err = 1'b1;
						end
					end
					CMD_STATUS: begin
						cml_clr = 1'b1;
					end
					default: begin
						next_s.err = 1'b1;
					end
				endcase
			end else begin
				case (link.code)
					CMD_CUR_WARN:   next_s.rdata = s.cur_warn;
					CMD_OT_FAULT:   next_s.rdata = s.ot_fault;
					CMD_OT_ACTION:  next_s.rdata = {8'h0, ot_action};
					CMD_OT_WARN:    next_s.rdata = s.ot_warn;
					CMD_VIN_OV:     next_s.rdata = s.vin_ov;
					CMD_VIN_OV_ACT: next_s.rdata = {8'h0, VIN_OV_RESPONSE, RETRY_NONE, ACT_DELAY};
					CMD_PG_ON:      next_s.rdata = s.pg_on;
					CMD_PG_OFF:     next_s.rdata = s.pg_off;
					CMD_TON:        next_s.rdata = s.ton;
					CMD_STATUS:     next_s.rdata = s.status;
					default:        next_s.err   = 1'b1;
				endcase
			end
			cml_set = next_s.err;
		end
		// A new error in the clearing cycle keeps the flag set
		next_s.cml = cml_set || (s.cml && !cml_clr);
		next_s.status             = 16'h0;
		next_s.status[ST_VOUT]    = vout_ov_i;
		next_s.status[ST_IOUT]    = oc_fault || oc_warn;
		next_s.status[ST_INPUT]   = vin_ovf || vin_uv_i;
		next_s.status[ST_PG_N]    = !next_s.pgood;
		next_s.status[ST_OFF]     = !next_s.out_en;
		next_s.status[ST_VOUT_OV] = vout_ov_i;
		next_s.status[ST_IOUT_OC] = oc_fault;
		next_s.status[ST_VIN_UV]  = vin_uv_i;
		next_s.status[ST_TEMP]    = ot_flt || ot_wrn;
		next_s.status[ST_CML]     = next_s.cml;
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s          <= '0;
			s.cur_warn <= CUR_WARN_RST;
			s.ot_fault <= OT_FAULT_RST;
			s.ot_warn  <= OT_WARN_RST;
			s.vin_ov   <= VIN_OV_RST;
			s.pg_on    <= PG_ON_RST;
			s.pg_off   <= PG_OFF_RST;
			s.ton      <= TON_RST;
			s.ot_retry <= OT_RETRY_RST;
		end else begin
			s <= next_s;
		end
	end
	assign out_en_o   = s.out_en;
	assign pgood_o    = s.pgood;
	assign status_o   = s.status;
	assign link.ack   = s.ack;
	assign link.err   = s.err;
	assign link.rdata = s.rdata;
endmodule
`default_nettype wire

// ==== design/pfl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfl_host
	import pfl_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	pfl_if.host              link,
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i
);
	import pfl_pkg::*;

	typedef struct packed {
		logic        aw_held;
		logic        w_held;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [7:0]  code;
		logic        write;
		logic [15:0] cmd_wdata;
		logic        busy;
		logic        err;
		logic [15:0] link_rdata;
		logic        req;
	} pfl_host_s;

	pfl_host_s s;
	pfl_host_s next_s;

	always_comb begin
		next_s = s;
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end

		// Request stays up until the device's one-cycle answer
		if (s.req && link.ack) begin
			next_s.req        = 1'b0;
			next_s.busy       = 1'b0;
			next_s.err        = link.err;
			next_s.link_rdata = link.rdata;
		end

		if (s_axi_awvalid_i && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = s_axi_wdata_i;
			next_s.wstrb  = s_axi_wstrb_i;
		end
		if (next_s.aw_held && next_s.w_held && !next_s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = AXI_OKAY;
			// Full decode, so an unaligned offset answers SLVERR instead of aliasing
			case (next_s.awaddr)
				HREG_CMD: begin
					// A start while a command is in flight is dropped
					if (next_s.wstrb[0] && !s.busy) begin
						next_s.code  = next_s.wdata[7:0];
						next_s.write = next_s.wdata[HCMD_WRITE_BIT];
						next_s.busy  = 1'b1;
						next_s.err   = 1'b0;
						next_s.req   = 1'b1;
					end
				end
				HREG_WDATA: begin
					if (next_s.wstrb[0]) next_s.cmd_wdata[7:0]  = next_s.wdata[7:0];
					if (next_s.wstrb[1]) next_s.cmd_wdata[15:8] = next_s.wdata[15:8];
				end
				HREG_STATUS, HREG_RDATA: begin
				end
				default: next_s.bresp = AXI_SLVERR;
			endcase
		end

		if (s_axi_arvalid_i && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = AXI_OKAY;
			next_s.rdata  = 32'h0;
			case (s_axi_araddr_i)
				HREG_CMD:    next_s.rdata = {23'h0, s.write, s.code};
				HREG_WDATA:  next_s.rdata = {16'h0, s.cmd_wdata};
				HREG_STATUS: begin
					next_s.rdata[HST_BUSY_BIT] = s.busy;
					next_s.rdata[HST_ERR_BIT]  = s.err;
				end
				HREG_RDATA:  next_s.rdata = {16'h0, s.link_rdata};
				default:     next_s.rresp = AXI_SLVERR;
			endcase
		end

		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready  = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready_o = s.awready;
	assign s_axi_wready_o  = s.wready;
	assign s_axi_bvalid_o  = s.bvalid;
	assign s_axi_bresp_o   = s.bresp;
	assign s_axi_arready_o = s.arready;
	assign s_axi_rvalid_o  = s.rvalid;
	assign s_axi_rresp_o   = s.rresp;
	assign s_axi_rdata_o   = s.rdata;
	assign link.req        = s.req;
	assign link.write      = s.write;
	assign link.code       = s.code;
	assign link.wdata      = s.cmd_wdata;
endmodule
`default_nettype wire

// ==== verification/pfl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfl_chk
	import pfl_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        req,
	input wire logic        write,
	input wire logic [7:0]  code,
	input wire logic [15:0] wdata,
	input wire logic        ack,
	input wire logic        err,
	input wire logic [15:0] rdata
);
	logic wr_tk;
	logic rd_tk;
	// A request counts once, at the edge where ack is still low
	assign wr_tk = req && !ack && write;
	assign rd_tk = req && !ack && !write;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	chk_cur_warn_range: assert property (wr_tk && code == CMD_CUR_WARN &&
		(wdata < CUR_WARN_MIN || wdata > CUR_WARN_MAX) |=> ack && err)
		else $error("current warning limit outside range accepted");
	chk_ot_fault_range: assert property (wr_tk && code == CMD_OT_FAULT &&
		(wdata < OT_FAULT_MIN || wdata > OT_FAULT_MAX) |=> ack && err)
		else $error("temperature fault limit outside range accepted");
	chk_ot_warn_range: assert property (wr_tk && code == CMD_OT_WARN &&
		(wdata < OT_WARN_MIN || wdata > OT_WARN_MAX) |=> ack && err)
		else $error("temperature warning limit outside range accepted");
	chk_vin_ov_range: assert property (wr_tk && code == CMD_VIN_OV |=> ack &&
		err == ($past(wdata) < VIN_OV_MIN || $past(wdata) > VIN_OV_MAX))
		else $error("input overvoltage limit range handling wrong");
	chk_pg_on_range: assert property (wr_tk && code == CMD_PG_ON &&
		(wdata < PG_ON_MIN || wdata > PG_ON_MAX) |=> ack && err)
		else $error("power good on level outside range accepted");
	chk_pg_off_range: assert property (wr_tk && code == CMD_PG_OFF &&
		(wdata < PG_OFF_MIN || wdata > PG_OFF_MAX) |=> ack && err)
		else $error("power good off level outside range accepted");
	chk_ton_range: assert property (wr_tk && code == CMD_TON |->
		##1 ack && err == ($past(wdata) > TON_MAX) ##1 !ack)
		else $error("turn on delay range handling wrong");
	chk_vin_act_ro: assert property (wr_tk && code == CMD_VIN_OV_ACT |=> ack && !err)
		else $error("write to fixed overvoltage action refused");
	chk_vin_act_val: assert property (rd_tk && code == CMD_VIN_OV_ACT |=> ack &&
		rdata == 16'h00c0)
		else $error("overvoltage action byte wrong");
	chk_ot_act_val: assert property (rd_tk && code == CMD_OT_ACTION |=> ack &&
		(rdata == 16'h00b8 || rdata == 16'h0080))
		else $error("temperature action byte wrong");
	chk_status_unused: assert property (rd_tk && code == CMD_STATUS |=> ack &&
		(rdata & 16'h1781) == 16'h0000)
		else $error("unsupported status bit set");
endmodule
`default_nettype wire

// ==== verification/pmbus_fault_limit_response_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmbus_fault_limit_response_regs_tb;
	import pfl_pkg::*;
	localparam int MS_P = 4;
	localparam int LIMIT = 30000;
	localparam logic [7:0] RCODE [7] = '{CMD_CUR_WARN, CMD_OT_FAULT, CMD_OT_WARN,
		CMD_VIN_OV, CMD_PG_ON, CMD_PG_OFF, CMD_TON};
	localparam logic [15:0] RRST [7] = '{CUR_WARN_RST, OT_FAULT_RST, OT_WARN_RST,
		VIN_OV_RST, PG_ON_RST, PG_OFF_RST, TON_RST};
	// Entries are {refused, code, value}; order matters for the cross-checks
	localparam logic [24:0] TBL [33] = '{25'h14a0013, 25'h04a0014, 25'h04a004a,
		25'h14a004b, 25'h0510019, 25'h1510018, 25'h04f008c, 25'h14f008d, 25'h051007d,
		25'h151007e, 25'h14f007d, 25'h04f007e, 25'h14f0018, 25'h155002f, 25'h0550030,
		25'h055005a, 25'h155005b, 25'h0550041, 25'h15e0069, 25'h05e006a, 25'h15e0076,
		25'h05e0075, 25'h05f0065, 25'h15f0066, 25'h15f004b, 25'h05f004c, 25'h05e005c,
		25'h15e005b, 25'h15f004d, 25'h06001f4, 25'h16001f5, 25'h0600000, 25'h0600002};
	logic        clock_i;
	logic        rst_i;
	logic        on_cmd, bias_ok, vout_ov, vin_uv, out_en, pgood;
	logic [15:0] iout, temp, vin, vout, status;
	logic [3:0]  awaddr, araddr, wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] shadow [256];
	int          n_fail, n_compared, cycles;

	pfl_if pfl_if_inst ();
	pfl_dev #(.MS_CYCLES_P(MS_P)) pfl_dev_inst (.clock_i(clock_i), .rst_i(rst_i),
		.link(pfl_if_inst), .on_cmd_i(on_cmd), .bias_ok_i(bias_ok), .iout_i(iout),
		.temp_i(temp), .vin_i(vin), .vout_i(vout), .vout_ov_i(vout_ov), .vin_uv_i(vin_uv),
		.out_en_o(out_en), .pgood_o(pgood), .status_o(status));
	pfl_host pfl_host_inst (.clock_i(clock_i), .rst_i(rst_i), .link(pfl_if_inst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	pfl_chk pfl_chk_inst (.clock_i(clock_i), .rst_i(rst_i), .req(pfl_if_inst.req),
		.write(pfl_if_inst.write), .code(pfl_if_inst.code), .wdata(pfl_if_inst.wdata),
		.ack(pfl_if_inst.ack), .err(pfl_if_inst.err), .rdata(pfl_if_inst.rdata));

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles > LIMIT) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Each bus task starts one edge on, so no strobe is driven twice in a time step
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic link(input logic [7:0] c, input logic wr, input logic [15:0] v,
		output logic [15:0] rd, output logic e);
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr(HREG_WDATA, {16'h0000, v}, r);
		axi_wr(HREG_CMD, {23'h000000, wr, c}, r);
		do axi_rd(HREG_STATUS, s, r); while (s[HST_BUSY_BIT] !== 1'b0);
		e = s[HST_ERR_BIT];
		axi_rd(HREG_RDATA, s, r);
		rd = s[15:0];
	endtask

	task automatic wait_en(input logic v, input int lim);
		int n;
		n = 0;
		while (out_en !== v && n < lim) begin
			@(posedge clock_i);
			n++;
		end
		check(out_en, v);
	endtask

	task automatic t_regs();
		logic [15:0] d;
		logic        e;
		logic [31:0] s;
		logic [1:0]  r;
		for (int i = 0; i < 7; i++) begin
			link(RCODE[i], 1'b0, 16'h0000, d, e);
			check({e, d}, {1'b0, RRST[i]});
			shadow[RCODE[i]] = RRST[i];
		end
		link(CMD_OT_ACTION, 1'b0, 16'h0000, d, e);
		check(d, 16'h00b8);
		axi_rd(HREG_CMD, s, r);
		check(s, {23'h000000, 1'b0, CMD_OT_ACTION});
		axi_wr(HREG_WDATA, 32'h0000a5c3, r);
		axi_rd(HREG_WDATA, s, r);
		check(s, 32'h0000a5c3);
		axi_rd(4'h2, s, r);
		check(r, AXI_SLVERR);
		axi_wr(4'h6, 32'h00000000, r);
		check(r, AXI_SLVERR);
	endtask

	task automatic t_ranges();
		logic [15:0] d;
		logic        e;
		for (int i = 0; i < 33; i++) begin
			link(TBL[i][23:16], 1'b1, TBL[i][15:0], d, e);
			check(e, TBL[i][24]);
			if (!TBL[i][24]) shadow[TBL[i][23:16]] = TBL[i][15:0];
			link(TBL[i][23:16], 1'b0, 16'h0000, d, e);
			check(d, shadow[TBL[i][23:16]]);
		end
	endtask

	task automatic t_actions();
		logic [15:0] d;
		logic        e;
		link(CMD_OT_ACTION, 1'b1, 16'h00ff, d, e);
		link(CMD_OT_ACTION, 1'b0, 16'h0000, d, e);
		check(d, 16'h00b8);
		link(CMD_OT_ACTION, 1'b1, 16'h0000, d, e);
		link(CMD_OT_ACTION, 1'b1, 16'h0010, d, e);
		check(e, 1'b1);
		link(CMD_OT_ACTION, 1'b0, 16'h0000, d, e);
		check(d, 16'h0080);
		link(CMD_VIN_OV_ACT, 1'b1, 16'h0000, d, e);
		check(e, 1'b0);
		link(CMD_VIN_OV_ACT, 1'b0, 16'h0000, d, e);
		check(d, 16'h00c0);
	endtask

	task automatic t_cml();
		logic [15:0] d;
		logic        e;
		link(8'h40, 1'b1, 16'h0001, d, e);
		check(e, 1'b1);
		link(CMD_STATUS, 1'b0, 16'h0000, d, e);
		check(d[ST_CML], 1'b1);
		link(CMD_STATUS, 1'b1, 16'h0000, d, e);
		link(CMD_STATUS, 1'b0, 16'h0000, d, e);
		check(d[ST_CML], 1'b0);
	endtask

	task automatic t_faults();
		logic [15:0] d;
		logic        e;
		link(CMD_OT_ACTION, 1'b1, 16'h00b8, d, e);
		on_cmd <= 1'b1;
		repeat (MS_P) @(posedge clock_i);
		check(out_en, 1'b0);
		wait_en(1'b1, 2 * MS_P + 6);
		iout <= 16'd90;
		wait_en(1'b0, 2);
		repeat (2) @(posedge clock_i);
		check({status[ST_IOUT], status[ST_OFF], status[ST_IOUT_OC]}, 3'h7);
		iout <= 16'd10;
		wait_en(1'b1, 2 * MS_P + 6);
		temp <= 16'd200;
		wait_en(1'b0, 2);
		repeat (2) @(posedge clock_i);
		check(status[ST_TEMP], 1'b1);
		temp <= 16'd40;
		wait_en(1'b1, 2 * MS_P + 6);
		link(CMD_OT_ACTION, 1'b1, 16'h0000, d, e);
		temp <= 16'd200;
		wait_en(1'b0, 2);
		temp <= 16'd40;
		repeat (4 * MS_P) @(posedge clock_i);
		check(out_en, 1'b0);
		on_cmd <= 1'b0;
		repeat (2) @(posedge clock_i);
		on_cmd <= 1'b1;
		wait_en(1'b1, 2 * MS_P + 6);
		vin <= 16'd100;
		wait_en(1'b0, 2);
		repeat (4 * MS_P) @(posedge clock_i);
		check({out_en, status[ST_INPUT]}, 2'h1);
		vin <= 16'd50;
		wait_en(1'b1, 2 * MS_P + 6);
		bias_ok <= 1'b0;
		wait_en(1'b0, 2);
		bias_ok <= 1'b1;
		wait_en(1'b1, 2 * MS_P + 6);
	endtask

	task automatic t_pgood();
		vout <= 16'd100;
		vout_ov <= 1'b1;
		vin_uv <= 1'b1;
		repeat (3) @(posedge clock_i);
		check({pgood, status[ST_PG_N]}, 2'h2);
		check(status & 16'ha028, 16'ha028);
		vout <= 16'd70;
		vout_ov <= 1'b0;
		vin_uv <= 1'b0;
		repeat (3) @(posedge clock_i);
		check({pgood, status[ST_PG_N]}, 2'h1);
	endtask

	initial begin
		rst_i = 1'b1;
		{on_cmd, vout_ov, vin_uv, awvalid, wvalid, bready, arvalid, rready} = '0;
		bias_ok = 1'b1;
		{awaddr, araddr, wstrb, wdata} = '0;
		{iout, temp, vin, vout} = {16'd10, 16'd40, 16'd50, 16'd0};
		{n_fail, n_compared, cycles} = '0;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs();
		t_ranges();
		t_actions();
		t_cml();
		t_faults();
		t_pgood();
		end_sim();
	end
endmodule
`default_nettype wire
